// ### design/ors_pkg.sv
// Package with the map, field positions, reset values and timing counts
package ors_pkg;

   localparam logic [15:0] OFS_PROG_CTRL = 16'h001e;
   localparam logic [15:0] OFS_BOOT_CTRL = 16'h0020;
   localparam logic [15:0] OFS_OPTION    = 16'h002f;
   localparam logic [15:0] BOOT_ROM_LO   = 16'h1e00;
   localparam logic [15:0] BOOT_ROM_HI   = 16'h1fef;

   localparam int OPT_OSC_BIT     = 0;
   localparam int OPT_SEC_BIT     = 1;
   localparam int PRG_OPT_PWR_BIT = 2;
   localparam int BOOT_START_BIT  = 0;
   localparam int BOOT_VERIFY_BIT = 1;
   localparam int BOOT_ST_BUSY    = 0;
   localparam int BOOT_ST_VERIFY  = 1;
   localparam int BOOT_ST_MODE    = 2;

   localparam logic [7:0] OPT_LATCH_RST = 8'h00;
   localparam logic [7:0] OPT_CELL_RST  = 8'h00;
   localparam logic [7:0] UNDEF_DATA    = 8'hff;
   localparam logic [7:0] RDATA_RST     = 8'h00;

   localparam int CLK_PERIOD_NS  = 20;
   localparam int T_OPT_PGM_NS   = 4000;
   localparam int T_BYTE_PGM_NS  = 1000000;
   localparam logic [15:0] OPT_PGM_CYC =
      16'((T_OPT_PGM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int BYTE_PGM_CYC_DEF =
      (T_BYTE_PGM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ST_FILL0,
      ST_FILL1,
      ST_SAMPLE,
      ST_RUN
   } ors_rst_st_t;

   function automatic logic ors_in_boot_rom(input logic [15:0] a);
      ors_in_boot_rom = (a >= BOOT_ROM_LO) && (a <= BOOT_ROM_HI);
   endfunction : ors_in_boot_rom

endpackage : ors_pkg

// ### design/ors_tmr_if.sv
// Interface between the main block and its programming-time counter
`timescale 1ns/1ns
interface ors_tmr_if;
   logic        run;
   logic [15:0] len;
   logic        done;
   modport ctl (output run, output len, input done);
   modport tmr (input run, input len, output done);
endinterface : ors_tmr_if

// ### design/ors_timer.sv
// Programming-time counter: done after len-1 cycles of run
`timescale 1ns/1ns
module ors_timer
   import ors_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   ors_tmr_if.tmr   t
);

   typedef struct packed {
      logic [15:0] cnt;
      logic        done;
   } ors_tmr_st_t;

   ors_tmr_st_t s_ff;
   ors_tmr_st_t nxt_s;

   // Done rises early by one so the byte owner's power flag (arr_pgm_power) spans exactly len
   always_comb begin
      nxt_s = s_ff;
      if (!t.run) begin
         nxt_s.cnt  = 16'h0000;
         nxt_s.done = 1'b0;
      end else begin
         nxt_s.cnt = s_ff.cnt + 16'h0001;
         if (s_ff.cnt == t.len - 16'h0002) begin
            nxt_s.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign t.done = s_ff.done;

endmodule : ors_timer

// ### design/ors_top.sv
// Option register, security gate, oscillator select and boot entry logic
`timescale 1ns/1ns
module ors_top
   import ors_pkg::*;
#(
   parameter int BYTE_PGM_CYC = BYTE_PGM_CYC_DEF
)
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [15:0] addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [7:0]  rdata,
   input  wire logic        irq_vpp_at_test,
   input  wire logic        irq_vpp_present,
   input  wire logic        port_b1_capture,
   input  wire logic        arr_rd,
   input  wire logic [7:0]  arr_rdata_in,
   output logic      [7:0]  arr_rdata,
   output logic             arr_deny,
   input  wire logic        fetch_vld,
   input  wire logic [15:0] fetch_addr,
   output logic             boot_rom_sel,
   output logic             osc_pins_en,
   output logic             port_b23_en,
   output logic             opt_pgm_power,
   output logic             arr_pgm_power,
   output logic             boot_mode,
   output logic             cpu_run
);

   typedef struct packed {
      logic        irq_s1;
      logic        irq_s2;
      logic        pb1_s1;
      logic        pb1_s2;
      logic        vpp_s1;
      logic        vpp_s2;
      ors_rst_st_t st;
      logic        boot;
      logic        cpu_run;
      logic        osc_act;
      logic        sec_act;
      logic        osc_en;
      logic        pb_en;
      logic [7:0]  opt_latch;
      logic        option_program_power_bit;
      logic        byte_busy;
      logic        verify;
      logic [7:0]  rdata;
      logic [7:0]  arr_rdata;
      logic        arr_deny;
      logic        rom_sel;
   } ors_st_t;

   ors_st_t s_ff;
   ors_st_t nxt_s;
   // Cells are nonvolatile: the reset pin must leave them alone
   logic [7:0]  opt_cell_ff = OPT_CELL_RST;
   logic [7:0]  nxt_opt_cell;

   ors_tmr_if opt_t ();
   ors_tmr_if byte_t ();

   // Cells only see power while the pin really carries it
   assign opt_t.run  = s_ff.option_program_power_bit & s_ff.vpp_s2;
   assign opt_t.len  = OPT_PGM_CYC;
   assign byte_t.run = s_ff.byte_busy;
   assign byte_t.len = 16'(BYTE_PGM_CYC);

   ors_timer u_opt_tmr (
      .clk    (clk),
      .arst_n (arst_n),
      .t      (opt_t.tmr)
   );

   ors_timer u_byte_tmr (
      .clk    (clk),
      .arst_n (arst_n),
      .t      (byte_t.tmr)
   );

   always_comb begin
      logic [7:0] rv;
      logic       deny;
      rv    = 8'h00;
      deny  = 1'b0;
      nxt_s = s_ff;
      nxt_opt_cell = opt_cell_ff;
      nxt_s.irq_s1 = irq_vpp_at_test;
      nxt_s.irq_s2 = s_ff.irq_s1;
      nxt_s.pb1_s1 = port_b1_capture;
      nxt_s.pb1_s2 = s_ff.pb1_s1;
      nxt_s.vpp_s1 = irq_vpp_present;
      nxt_s.vpp_s2 = s_ff.vpp_s1;

      // Wait for the synchronisers to fill before trusting the straps
      case (s_ff.st)
         ST_FILL0: nxt_s.st = ST_FILL1;
         ST_FILL1: nxt_s.st = ST_SAMPLE;
         ST_SAMPLE: begin
            nxt_s.st      = ST_RUN;
            nxt_s.boot    = s_ff.irq_s2 & s_ff.pb1_s2;
            nxt_s.osc_act = opt_cell_ff[OPT_OSC_BIT];
            nxt_s.sec_act = opt_cell_ff[OPT_SEC_BIT];
            nxt_s.osc_en  = opt_cell_ff[OPT_OSC_BIT];
            nxt_s.pb_en   = ~opt_cell_ff[OPT_OSC_BIT];
            nxt_s.cpu_run = 1'b1;
         end
         ST_RUN: nxt_s.st = ST_RUN;
         default: nxt_s.st = ST_FILL0;
      endcase

      // Latch is frozen while power is on so the cells see stable data
      if (wr && addr == OFS_OPTION && !s_ff.option_program_power_bit) begin
         nxt_s.opt_latch = wdata;
      end
      if (wr && addr == OFS_PROG_CTRL) begin
         nxt_s.option_program_power_bit = wdata[PRG_OPT_PWR_BIT];
      end
      if (opt_t.done) begin
         nxt_opt_cell = s_ff.opt_latch;
      end

      // Single pass: after verify is set no byte program can start; a start in the same write as verify still runs
      if (byte_t.done) begin
         nxt_s.byte_busy = 1'b0;
      end
      if (wr && addr == OFS_BOOT_CTRL && s_ff.boot) begin
         if (wdata[BOOT_START_BIT] && !s_ff.verify
             && !s_ff.byte_busy) begin
            nxt_s.byte_busy = 1'b1;
         end
         if (wdata[BOOT_VERIFY_BIT] && !s_ff.byte_busy) begin
            nxt_s.verify = 1'b1;
         end
      end

      case (addr)
         OFS_OPTION:    rv[OPT_OSC_BIT] = s_ff.osc_act;
         OFS_PROG_CTRL: rv[PRG_OPT_PWR_BIT] = s_ff.option_program_power_bit;
         OFS_BOOT_CTRL: begin
            rv[BOOT_ST_BUSY]   = s_ff.byte_busy;
            rv[BOOT_ST_VERIFY] = s_ff.verify;
            rv[BOOT_ST_MODE]   = s_ff.boot;
         end
         default: rv = 8'h00;
      endcase
      nxt_s.rdata = rd ? rv : RDATA_RST;

      deny = arr_rd & s_ff.sec_act & s_ff.boot;
      nxt_s.arr_deny  = deny;
      nxt_s.arr_rdata = deny ? UNDEF_DATA : arr_rdata_in;
      nxt_s.rom_sel   = fetch_vld & s_ff.boot
                        & ors_in_boot_rom(fetch_addr);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_ff           <= '0;
         s_ff.st        <= ST_FILL0;
         s_ff.pb_en     <= 1'b1;
         s_ff.opt_latch <= OPT_LATCH_RST;
         s_ff.rdata     <= RDATA_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   always_ff @(posedge clk) begin
      opt_cell_ff <= nxt_opt_cell;
   end

   assign rdata         = s_ff.rdata;
   assign arr_rdata     = s_ff.arr_rdata;
   assign arr_deny      = s_ff.arr_deny;
   assign boot_rom_sel  = s_ff.rom_sel;
   assign osc_pins_en   = s_ff.osc_en;
   assign port_b23_en   = s_ff.pb_en;
   assign opt_pgm_power = s_ff.option_program_power_bit;
   assign arr_pgm_power = s_ff.byte_busy;
   assign boot_mode     = s_ff.boot;
   assign cpu_run       = s_ff.cpu_run;

   // Helper: length of the current array power pulse
   logic [31:0] pw_cnt_ff;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pw_cnt_ff <= 32'h0;
      end else begin
         pw_cnt_ff <= s_ff.byte_busy ? pw_cnt_ff + 32'h1 : 32'h0;
      end
   end

   property p_sec_deny;
      @(posedge clk) disable iff (!arst_n)
      arr_rd && boot_mode && s_ff.sec_act
      |=> arr_deny && arr_rdata == UNDEF_DATA;
   endproperty
   a_sec_deny: assert property (p_sec_deny)
      else $error("secured array read not refused");

   property p_sec_pass;
      @(posedge clk) disable iff (!arst_n)
      arr_rd && !(boot_mode && s_ff.sec_act)
      |=> !arr_deny && arr_rdata == $past(arr_rdata_in);
   endproperty
   a_sec_pass: assert property (p_sec_pass)
      else $error("permitted array read altered");

   property p_osc_swap;
      @(posedge clk) disable iff (!arst_n)
      cpu_run |-> osc_pins_en != port_b23_en
                  && (!$past(cpu_run) || $stable(osc_pins_en));
   endproperty
   a_osc_swap: assert property (p_osc_swap)
      else $error("oscillator and port pins not exclusive");

   property p_opt_read;
      @(posedge clk) disable iff (!arst_n)
      rd && addr == OFS_OPTION
      |=> rdata[OPT_OSC_BIT] == osc_pins_en && !rdata[OPT_SEC_BIT];
   endproperty
   a_opt_read: assert property (p_opt_read)
      else $error("option register read wrong");

   property p_boot_entry;
      @(posedge clk) disable iff (!arst_n)
      $rose(cpu_run)
      |-> boot_mode == ($past(s_ff.irq_s2) && $past(s_ff.pb1_s2));
   endproperty
   a_boot_entry: assert property (p_boot_entry)
      else $error("boot entry strap mismatch");

   property p_rom_sel;
      @(posedge clk) disable iff (!arst_n)
      fetch_vld && boot_mode |=> boot_rom_sel
         == $past(ors_in_boot_rom(fetch_addr));
   endproperty
   a_rom_sel: assert property (p_rom_sel)
      else $error("boot ROM window select wrong");

   property p_byte_time;
      @(posedge clk) disable iff (!arst_n)
      $fell(arr_pgm_power) |-> pw_cnt_ff == 32'(BYTE_PGM_CYC);
   endproperty
   a_byte_time: assert property (p_byte_time)
      else $error("byte programming time wrong");

   property p_one_pass;
      @(posedge clk) disable iff (!arst_n)
      s_ff.verify && !arr_pgm_power |=> !arr_pgm_power;
   endproperty
   a_one_pass: assert property (p_one_pass)
      else $error("byte programmed after verify began");

   property p_opt_power;
      @(posedge clk) disable iff (!arst_n)
      wr && addr == OFS_PROG_CTRL
      |=> opt_pgm_power == $past(wdata[PRG_OPT_PWR_BIT]);
   endproperty
   a_opt_power: assert property (p_opt_power)
      else $error("option power bit not following write");

   property p_sample_first;
      @(posedge clk) disable iff (!arst_n)
      $rose(cpu_run) |-> $past(s_ff.st) == ST_SAMPLE
                         && osc_pins_en == $past(opt_cell_ff[OPT_OSC_BIT]);
   endproperty
   a_sample_first: assert property (p_sample_first)
      else $error("run released before option sampling");

   c_boot: cover property (@(posedge clk) disable iff (!arst_n)
      $rose(cpu_run) && boot_mode);
   c_deny: cover property (@(posedge clk) disable iff (!arst_n)
      arr_deny);
   c_opt_pgm: cover property (@(posedge clk) disable iff (!arst_n)
      opt_t.done);
   c_byte: cover property (@(posedge clk) disable iff (!arst_n)
      $fell(arr_pgm_power));

endmodule : ors_top

// ### dv/ors_prog_model.sv
// Programmer board model: strap levels and programming voltage
`timescale 1ns/1ns
module ors_prog_model (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic boot_req,
   input  wire logic vpp_req,
   input  wire logic opt_pgm_power,
   output logic      irq_vpp_at_test = 1'b0,
   output logic      irq_vpp_present = 1'b0,
   output logic      port_b1_capture = 1'b0
);
   // Straps move only in reset, so they are steady at sampling
   always @(posedge clk) begin
      if (!arst_n) begin
         irq_vpp_at_test <= boot_req;
         port_b1_capture <= boot_req;
      end
   end
   // Voltage is kept until the power bit is cleared again
   always @(posedge clk) begin
      irq_vpp_present <= vpp_req | (irq_vpp_present & opt_pgm_power);
   end
endmodule : ors_prog_model

// ### dv/testbench.sv
// Self-checking bench for option register and boot entry logic
`timescale 1ns/1ns
module testbench;
   import ors_pkg::*;
   localparam int BYTE_CYC = 20;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [15:0] addr = '0;
   logic [7:0]  wdata = '0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        arr_rd = 1'b0;
   logic [7:0]  arr_in = '0;
   logic        fetch_vld = 1'b0;
   logic        boot_req = 1'b1;
   logic        vpp_req = 1'b0;
   logic [7:0]  rdata, arr_rdata;
   logic        arr_deny, rom_sel, osc_en, b23_en;
   logic        opt_pwr, arr_pwr, boot_mode, cpu_run;
   logic        at_test, vpp_on, b1;
   logic        rd_s = 1'b0, arr_s = 1'b0, fet_s = 1'b0;
   logic [8:0]  q_rd[$], q_arr[$], q_fet[$];
   logic [31:0] seed = 32'h860fbb46;
   int          failures = 0, compares = 0, cycles = 0, hi_cnt = 0, n;

   ors_top #(.BYTE_PGM_CYC(BYTE_CYC)) u_dut (.clk(clk), .arst_n(arst_n),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .irq_vpp_at_test(at_test), .irq_vpp_present(vpp_on),
      .port_b1_capture(b1), .arr_rd(arr_rd), .arr_rdata_in(arr_in),
      .arr_rdata(arr_rdata), .arr_deny(arr_deny), .fetch_vld(fetch_vld),
      .fetch_addr(addr), .boot_rom_sel(rom_sel), .osc_pins_en(osc_en),
      .port_b23_en(b23_en), .opt_pgm_power(opt_pwr),
      .arr_pgm_power(arr_pwr), .boot_mode(boot_mode), .cpu_run(cpu_run));

   ors_prog_model u_prog (.clk(clk), .arst_n(arst_n), .boot_req(boot_req),
      .vpp_req(vpp_req), .opt_pgm_power(opt_pwr),
      .irq_vpp_at_test(at_test), .irq_vpp_present(vpp_on),
      .port_b1_capture(b1));

   initial begin
      forever #10 clk = ~clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      xs = s ^ (s << 5);
   endfunction : xs

   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_of_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test

   // Strobes last one cycle; an idle cycle follows so none is set twice
   task automatic idle;
      @(posedge clk);
      {wr, rd, arr_rd, fetch_vld} <= 4'h0;
      @(posedge clk);
   endtask : idle

   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      idle();
   endtask : wr_reg

   task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
      addr <= a;
      rd <= 1'b1;
      q_rd.push_back({1'b0, e});
      idle();
   endtask : rd_reg

   task automatic arr(input logic deny);
      seed = xs(seed);
      arr_in <= seed[7:0];
      arr_rd <= 1'b1;
      q_arr.push_back(deny ? {1'b1, UNDEF_DATA} : {1'b0, seed[7:0]});
      idle();
   endtask : arr

   task automatic fet(input logic [15:0] a, input logic bm);
      addr <= a;
      fetch_vld <= 1'b1;
      q_fet.push_back({8'h00, bm && a >= BOOT_ROM_LO && a <= BOOT_ROM_HI});
      idle();
   endtask : fet

   task automatic do_reset(input logic boot, input logic osc);
      arst_n <= 1'b0;
      boot_req <= boot;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      // Look between edges so the settled outputs are seen
      @(negedge clk);
      chk({4'h0, cpu_run, boot_mode, osc_en, b23_en, opt_pwr},
          {4'h0, 1'b1, boot, osc, !osc, 1'b0});
      @(posedge clk);
   endtask : do_reset

   // Watcher: the answer stands in the cycle after each strobe
   always @(negedge clk) begin
      if (rd_s) chk({1'b0, rdata}, q_rd.pop_front());
      if (arr_s) chk({arr_deny, arr_rdata}, q_arr.pop_front());
      if (fet_s) chk({8'h00, rom_sel}, q_fet.pop_front());
      if (arr_pwr) hi_cnt++;
      rd_s = rd;
      arr_s = arr_rd;
      fet_s = fetch_vld;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         end_of_test();
      end
   end

   initial begin
      do_reset(1'b1, 1'b0);
      rd_reg(OFS_OPTION, 8'h00);
      rd_reg(OFS_BOOT_CTRL, 8'h04);
      rd_reg(16'h0033, 8'h00);
      arr(1'b0);
      fet(16'h1dff, 1'b1);
      fet(BOOT_ROM_LO, 1'b1);
      fet(BOOT_ROM_HI, 1'b1);
      fet(16'h1ff0, 1'b1);
      $display("test boot_map done");
      // Second start lands while busy and must not stretch the pulse
      n = hi_cnt;
      wr_reg(OFS_BOOT_CTRL, 8'h01);
      wr_reg(OFS_BOOT_CTRL, 8'h01);
      repeat (30) @(posedge clk);
      chk(9'(hi_cnt - n), 9'(BYTE_CYC));
      wr_reg(OFS_BOOT_CTRL, 8'h02);
      rd_reg(OFS_BOOT_CTRL, 8'h06);
      n = hi_cnt;
      wr_reg(OFS_BOOT_CTRL, 8'h01);
      repeat (5) @(posedge clk);
      chk(9'(hi_cnt - n), 9'h000);
      $display("test byte_program done");
      // Array verified above, only now is security programmed
      wr_reg(OFS_OPTION, 8'h03);
      vpp_req <= 1'b1;
      wr_reg(OFS_PROG_CTRL, 8'h04);
      rd_reg(OFS_PROG_CTRL, 8'h04);
      wr_reg(OFS_OPTION, 8'h00);
      repeat (OPT_PGM_CYC + 10) @(posedge clk);
      wr_reg(OFS_PROG_CTRL, 8'h00);
      vpp_req <= 1'b0;
      rd_reg(OFS_OPTION, 8'h00);
      $display("test option_program done");
      do_reset(1'b1, 1'b1);
      rd_reg(OFS_OPTION, 8'h01);
      arr(1'b1);
      arr(1'b1);
      $display("test secure_boot done");
      wr_reg(OFS_PROG_CTRL, 8'h04);
      do_reset(1'b0, 1'b1);
      arr(1'b0);
      fet(BOOT_ROM_LO, 1'b0);
      rd_reg(OFS_BOOT_CTRL, 8'h00);
      $display("test user_mode done");
      repeat (3) @(posedge clk);
      end_of_test();
   end
endmodule : testbench
